// ### hdl/mcss_top.sv
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
// Contract
// [RQ1] Crystal low power bit picks quick start or low power
// [RQ2] Power on clears crystal low power bit
// [RQ3] Software sets low power about 2 s later
// [RQ4] Slow crystal runs whatever low power setting
// [RQ5] System clock from fast path or slow clock
// [RQ6] Divided fast path ratio from 2 to 64
// [RQ7] Fast clock from one of four sources
// [RQ8] Slow clock from crystal or internal RC
// [RQ9] Substitute and time base clocks each selectable
// [RQ10] Substitute clock drives processor right after wake
// [RQ11] Slow selection stops the fast oscillator
// [RQ12] Watchdog from substitute or system divided four
// [RQ13] Time base clock feeds time base and timers
// [RQ14] LCD clocked from substitute clock
// [RQ15] Fast internal RC offers 4, 8, 12 MHz
// [RQ16] External clock filter can be disabled
// [RQ17] Unused crystal releases its two pins
// [RQ18] Codes 000/001 slow, 010 /64, 011 /32
// [RQ19] Source changes only at a clock boundary
module mcss_top import mcss_pkg::*; (
   input wire logic core_clk, // Block clock, 250 MHz
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic ce, // Clock enable, freezes all state
   input wire mcss_cfg_t cfg, // Configuration options
   input wire mcss_osc_t osc, // Oscillator ticks
   input wire logic fast_stable, // Fast oscillator has settled
   input wire logic slow_stable, // Slow oscillator has settled
   input wire logic wake, // Wake up event, one cycle
   input wire logic [7:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   output mcss_tick_t tick, // Derived clock enables
   output logic fast_osc_en, // Fast oscillator enable
   output logic slow_xtal_en, // Slow crystal oscillator enable
   output logic slow_xtal_lp, // Slow crystal low power mode
   output logic [1:0] irc_freq_sel, // Fast internal RC frequency
   output logic ext_filter_en, // External clock noise filter on
   output logic xtal_pins_free, // Crystal pins are plain I/O
   output logic on_sub // Processor runs on substitute clock
);

   // Decode of the divide ratio select field, used for the path choice
   function automatic logic div_is_slow(input logic [2:0] code);
      div_is_slow = (code == MCSS_DIV_SLOW0) || (code == MCSS_DIV_SLOW1);
   endfunction

   // Log2 of the fast divide ratio for a given code
   function automatic logic [2:0] div_shift(input logic [2:0] code);
      case (code)
         MCSS_DIV_64: div_shift = 3'h6; // RQ18
         MCSS_DIV_32: div_shift = 3'h5; // RQ18
         MCSS_DIV_16: div_shift = 3'h4;
         MCSS_DIV_8: div_shift = 3'h3;
         MCSS_DIV_4: div_shift = 3'h2;
         MCSS_DIV_2: div_shift = 3'h1;
         default: div_shift = 3'h6;
      endcase
   endfunction

   // Wake handling states
   typedef enum logic [1:0] {
      MCSS_RUN = 2'b00, // Normal clocking
      MCSS_WAKE = 2'b01, // Substitute clock until the switch is on the chosen path
      MCSS_BAD = 2'b11 // Unused code, recovers to run
   } mcss_state_t;

   // Software registers
   logic [2:0] div_sel_ff; // Divide ratio select
   logic fast_start_ff; // Fast start enable
   logic idle_en_ff; // Idle enable
   logic speed_sel_ff; // Speed domain select
   logic crystal_low_power_select_ff; // Crystal low power select
   logic [7:0] rdata_ff; // Read data register

   // Clock state
   mcss_state_t state_ff; // Wake state
   mcss_state_t nxt_state; // Next wake state
   logic fast_rdy_ff; // Sampled fast ready flag
   logic slow_rdy_ff; // Sampled slow ready flag
   logic [1:0] wdt_cnt_ff; // System tick count for watchdog
   mcss_tick_t tick_ff; // Registered clock enables
   logic fast_en_ff; // Fast oscillator enable
   logic xtal_en_ff; // Slow crystal enable
   logic xtal_lp_ff; // Slow crystal low power output
   logic [1:0] irc_ff; // Fast RC frequency output
   logic filt_ff; // Filter enable output
   logic pins_ff; // Pin release output
   logic on_sub_ff; // Substitute clock in use

   // Combinational nets
   logic want_fast; // Software asks for the fast path
   logic [2:0] shift; // Prescaler shift
   logic fast_raw; // Tick of the chosen fast source
   logic slow_raw; // Slow clock tick
   logic sub_raw; // Substitute clock tick
   logic tbc_raw; // Time base clock tick
   logic fast_div; // Divided fast tick
   logic sw_on_fast; // Switch is on the fast path
   logic sw_tick; // Switch output tick
   logic sys_raw; // System tick before registering
   logic wdt_sys; // System divided by four
   logic xtal_used; // Slow crystal needed by any clock
   logic wr_smr; // Write to system mode register
   logic wr_tbc; // Write to time base control register
   logic [7:0] smr_view; // System mode register read view
   logic [7:0] tbc_view; // Time base control read view
   logic [7:0] nxt_rdata; // Read data selection
   logic [7:0] smr_wr_val; // Masked write to system mode register

   // Source selection, fixed by configuration
   assign fast_raw = osc.fast[cfg.fast_src]; // RQ7
   assign slow_raw = cfg.slow_is_rc ? osc.slow_rc : osc.slow_xtal; // RQ8
   assign sub_raw = cfg.sub_is_rc ? osc.slow_rc : osc.slow_xtal; // RQ9
   assign tbc_raw = cfg.tbc_is_rc ? osc.slow_rc : osc.slow_xtal; // RQ9

   // Speed bit high means undivided fast clock
   assign want_fast = speed_sel_ff || !div_is_slow(div_sel_ff); // RQ5
   assign shift = speed_sel_ff ? 3'h0 : div_shift(div_sel_ff); // RQ6

   // Slow crystal is needed if any clock takes it
   assign xtal_used = !cfg.slow_is_rc || !cfg.sub_is_rc
      || !cfg.tbc_is_rc;

   // Prescaler on the fast clock
   mcss_prescaler u_pre (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .run(fast_en_ff),
      .fast_tick(fast_raw),
      .shift(shift),
      .div_tick(fast_div)
   );

   // Boundary safe selection between fast path and slow clock
   mcss_switch u_sw (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .want_fast(want_fast),
      .fast_ok(fast_en_ff && fast_rdy_ff),
      .slow_tick(slow_raw),
      .fast_tick(fast_div),
      .on_fast(sw_on_fast),
      .sys_tick(sw_tick)
   );

   // After wake the substitute clock drives the processor
   assign sys_raw = (state_ff == MCSS_WAKE) ? sub_raw : sw_tick; // RQ10
   assign wdt_sys = sys_raw && (wdt_cnt_ff == MCSS_WDT_DIV_LAST);

   // Wake state: leave once the chosen path is actually clocking
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         MCSS_RUN: begin
            if (wake) begin
               nxt_state = MCSS_WAKE; // RQ10
            end
         end
         MCSS_WAKE: begin
            // Wait for a settled fast path or stay on slow selection
            if ((want_fast && sw_on_fast) || (!want_fast && !sw_on_fast)) begin
               nxt_state = MCSS_RUN;
            end
         end
         default: begin
            nxt_state = MCSS_RUN;
         end
      endcase
   end

   // Register port decode
   assign wr_smr = reg_wr && (reg_addr == MCSS_SMR_OFS);
   assign wr_tbc = reg_wr && (reg_addr == MCSS_TBC_OFS);
   assign smr_wr_val = reg_wdata & MCSS_SMR_WMASK;
   assign smr_view = {div_sel_ff, fast_start_ff, slow_rdy_ff, fast_rdy_ff,
      idle_en_ff, speed_sel_ff};
   assign tbc_view = {7'h00, crystal_low_power_select_ff};
   // Unmapped addresses read zero
   assign nxt_rdata = (reg_addr == MCSS_SMR_OFS) ? smr_view :
      (reg_addr == MCSS_TBC_OFS) ? tbc_view : 8'h00;

   // Software registers; reset is the power on state
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_sel_ff <= MCSS_DIV_RST;
         fast_start_ff <= MCSS_SMR_RST[MCSS_SMR_FSTEN];
         idle_en_ff <= MCSS_SMR_RST[MCSS_SMR_IDLE_EN];
         speed_sel_ff <= MCSS_SMR_RST[MCSS_SMR_SPEED];
         crystal_low_power_select_ff <= MCSS_CRYSTAL_LOW_POWER_SELECT_RST; // RQ2
      end else if (ce) begin
         if (wr_smr) begin
            div_sel_ff <= smr_wr_val[MCSS_SMR_DIV_HI:MCSS_SMR_DIV_LO];
            fast_start_ff <= smr_wr_val[MCSS_SMR_FSTEN];
            idle_en_ff <= smr_wr_val[MCSS_SMR_IDLE_EN];
            speed_sel_ff <= smr_wr_val[MCSS_SMR_SPEED];
         end
         if (wr_tbc) begin
            // Software may set this once the crystal has settled
            crystal_low_power_select_ff <= reg_wdata[MCSS_TBC_CRYSTAL_LOW_POWER_SELECT]; // RQ3
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else if (ce) begin
         rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
      end
   end

   // Oscillator ready flags and wake state
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_rdy_ff <= 1'b0;
         slow_rdy_ff <= 1'b0;
         state_ff <= MCSS_RUN;
      end else if (ce) begin
         // A stopped fast oscillator stops being reported ready one cycle after its enable drops
         fast_rdy_ff <= fast_stable && fast_en_ff;
         slow_rdy_ff <= slow_stable;
         state_ff <= nxt_state;
      end
   end

   // Oscillator controls. The fast oscillator starts as soon as it is
   // wanted but the switch waits for it to settle before moving.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_en_ff <= 1'b1;
         xtal_en_ff <= 1'b0;
         xtal_lp_ff <= MCSS_CRYSTAL_LOW_POWER_SELECT_RST;
         irc_ff <= MCSS_IRC_4MHZ;
         filt_ff <= 1'b0;
         pins_ff <= 1'b0;
      end else if (ce) begin
         // Off once the switch has left it and it is not wanted
         fast_en_ff <= want_fast || sw_on_fast; // RQ11
         xtal_en_ff <= xtal_used; // RQ4
         xtal_lp_ff <= crystal_low_power_select_ff; // RQ1
         irc_ff <= cfg.irc_freq; // RQ15
         filt_ff <= (cfg.fast_src == MCSS_FAST_EXT)
            && !cfg.ext_filter_off; // RQ16
         pins_ff <= !xtal_used && cfg.xt_pins_io; // RQ17
      end
   end

   // Derived clock enables, registered so outputs come from flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_ff <= '0;
         wdt_cnt_ff <= 2'h0;
         on_sub_ff <= 1'b0;
      end else if (ce) begin
         if (sys_raw) begin
            wdt_cnt_ff <= wdt_cnt_ff + 2'h1;
         end
         tick_ff.sys <= sys_raw;
         tick_ff.sub <= sub_raw;
         tick_ff.time_base_control_register <= tbc_raw; // RQ13
         tick_ff.tm <= tbc_raw; // RQ13
         tick_ff.lcd <= sub_raw; // RQ14
         tick_ff.wdt <= cfg.wdt_from_sys ? wdt_sys : sub_raw; // RQ12
         on_sub_ff <= (nxt_state == MCSS_WAKE);
      end
   end

   // Outputs
   assign reg_rdata = rdata_ff;
   assign tick = tick_ff;
   assign fast_osc_en = fast_en_ff;
   assign slow_xtal_en = xtal_en_ff;
   assign slow_xtal_lp = xtal_lp_ff;
   assign irc_freq_sel = irc_ff;
   assign ext_filter_en = filt_ff;
   assign xtal_pins_free = pins_ff;
   assign on_sub = on_sub_ff;

endmodule // mcss_top

// ### pkg/mcss_pkg.sv
// Shared constants and carriers for the clock source selection block
package mcss_pkg;

   // Register offsets on the plain register port
   localparam logic [7:0] MCSS_SMR_OFS = 8'h00; // System mode register
   localparam logic [7:0] MCSS_TBC_OFS = 8'h01; // Time base control register

   // System mode register field positions
   localparam int MCSS_SMR_DIV_HI = 7; // Divide ratio select, top bit
   localparam int MCSS_SMR_DIV_LO = 5; // Divide ratio select, low bit
   localparam int MCSS_SMR_FSTEN = 4; // Fast start enable
   localparam int MCSS_SMR_SLOW_RDY = 3; // Slow oscillator ready, read only
   localparam int MCSS_SMR_FAST_RDY = 2; // Fast oscillator ready, read only
   localparam int MCSS_SMR_IDLE_EN = 1; // Idle enable
   localparam int MCSS_SMR_SPEED = 0; // Speed domain select

   // Reset values
   localparam logic [7:0] MCSS_SMR_RST = 8'h03; // Speed and idle set
   localparam logic [2:0] MCSS_DIV_RST = 3'h0; // Divide ratio at reset
   localparam logic MCSS_CRYSTAL_LOW_POWER_SELECT_RST = 1'b0; // Quick start after power on

   // Time base control register field position
   localparam int MCSS_TBC_CRYSTAL_LOW_POWER_SELECT = 0; // Crystal low power select

   // Writable bit masks (ready flags are read only)
   localparam logic [7:0] MCSS_SMR_WMASK = 8'hF3; // Writable bits
   localparam logic [7:0] MCSS_TBC_WMASK = 8'h01; // Writable bits

   // Divide ratio select codes
   localparam logic [2:0] MCSS_DIV_SLOW0 = 3'h0; // Slow clock
   localparam logic [2:0] MCSS_DIV_SLOW1 = 3'h1; // Slow clock
   localparam logic [2:0] MCSS_DIV_64 = 3'h2; // Fast / 64
   localparam logic [2:0] MCSS_DIV_32 = 3'h3; // Fast / 32
   localparam logic [2:0] MCSS_DIV_16 = 3'h4; // Fast / 16
   localparam logic [2:0] MCSS_DIV_8 = 3'h5; // Fast / 8
   localparam logic [2:0] MCSS_DIV_4 = 3'h6; // Fast / 4
   localparam logic [2:0] MCSS_DIV_2 = 3'h7; // Fast / 2

   // Prescaler width: log2 of the largest ratio
   localparam int MCSS_PRE_W = 6; // Counts up to 64
   localparam logic [1:0] MCSS_WDT_DIV_LAST = 2'h3; // System / 4

   // Fast source choice
   typedef enum logic [1:0] {
      MCSS_FAST_XTAL = 2'b00, // Fast crystal oscillator
      MCSS_FAST_RC = 2'b01, // Resistor capacitor oscillator
      MCSS_FAST_EXT = 2'b10, // External clock input
      MCSS_FAST_IRC = 2'b11 // Fast internal RC oscillator
   } mcss_fast_src_t;

   // Fast internal RC frequency choice
   localparam logic [1:0] MCSS_IRC_4MHZ = 2'h0; // 4 MHz
   localparam logic [1:0] MCSS_IRC_8MHZ = 2'h1; // 8 MHz
   localparam logic [1:0] MCSS_IRC_12MHZ = 2'h2; // 12 MHz

   // Configuration options, fixed at build or fuse time
   typedef struct packed {
      mcss_fast_src_t fast_src; // Fast clock source
      logic [1:0] irc_freq; // Fast internal RC frequency
      logic ext_filter_off; // Disable external clock noise filter
      logic slow_is_rc; // Slow clock: 0 crystal, 1 internal RC
      logic sub_is_rc; // Substitute clock: 0 crystal, 1 RC
      logic tbc_is_rc; // Time base clock: 0 crystal, 1 RC
      logic wdt_from_sys; // Watchdog: 0 substitute, 1 system / 4
      logic xt_pins_io; // Ask for crystal pins as plain I/O
   } mcss_cfg_t;

   // Oscillator ticks, one cycle enables synchronous to core_clk
   typedef struct packed {
      logic [3:0] fast; // One per fast source, by source code
      logic slow_xtal; // Slow crystal oscillator
      logic slow_rc; // Slow internal RC oscillator
   } mcss_osc_t;

   // Derived clock enables
   typedef struct packed {
      logic sys; // System clock
      logic sub; // Substitute clock
      logic time_base_control_register; // Time base clock
      logic wdt; // Watchdog clock
      logic tm; // Timer module clock
      logic lcd; // LCD clock
   } mcss_tick_t;

endpackage

// ### hdl/mcss_prescaler.sv
`timescale 1ns/10ps
// Fast clock prescaler: one enable per 2**shift fast ticks
module mcss_prescaler import mcss_pkg::*; (
   input wire logic core_clk, // Block clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic ce, // Clock enable, freezes state
   input wire logic run, // Fast oscillator running
   input wire logic fast_tick, // Fast clock tick
   input wire logic [2:0] shift, // Log2 of divide ratio, 0 to 6
   output logic div_tick // Divided fast tick, one cycle
);

   logic [MCSS_PRE_W-1:0] cnt_ff; // Free running fast tick count
   logic [MCSS_PRE_W-1:0] mask; // Low bits that must all be set
   logic [MCSS_PRE_W-1:0] nxt_cnt; // Next count

   // Mask of the low shift bits; shift 0 gives every tick
   assign mask = MCSS_PRE_W'((7'h01 << shift) - 7'h01);
   assign nxt_cnt = cnt_ff + 6'h01;
   // Ratio change lands on the shared counter, so no short period
   assign div_tick = fast_tick && run && ((cnt_ff & mask) == mask);

   // Count only while the oscillator runs so a restart begins clean
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 6'h00;
      end else if (ce) begin
         if (!run) begin
            cnt_ff <= 6'h00;
         end else if (fast_tick) begin
            cnt_ff <= nxt_cnt;
         end
      end
   end

endmodule // mcss_prescaler

// ### hdl/mcss_switch.sv
`timescale 1ns/10ps
// Source switch that moves only right after a tick of the old source
module mcss_switch import mcss_pkg::*; (
   input wire logic core_clk, // Block clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic ce, // Clock enable, freezes state
   input wire logic want_fast, // Requested source: 1 fast path
   input wire logic fast_ok, // Fast path may be taken
   input wire logic slow_tick, // Slow clock tick
   input wire logic fast_tick, // Divided fast tick
   output logic on_fast, // Fast path in use
   output logic sys_tick // Selected tick
);

   logic on_fast_ff; // Current source
   logic cur_tick; // Tick of the current source
   logic move; // Switch now

   assign cur_tick = on_fast_ff ? fast_tick : slow_tick;
   // Move only on a boundary of the old source, never mid period
   assign move = cur_tick && (want_fast != on_fast_ff)
      && (fast_ok || !want_fast); // RQ19
   assign on_fast = on_fast_ff;
   assign sys_tick = cur_tick;

   // Selection register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         on_fast_ff <= 1'b0;
      end else if (ce && move) begin
         on_fast_ff <= want_fast; // RQ5
      end
   end

endmodule // mcss_switch

// ### bench/mcss_checker.sv
`timescale 1ns/10ps
// Port-level checks of the clock source selection block
module mcss_checker import mcss_pkg::*; (
   input wire logic core_clk, // Block clock
   input wire logic rst_n, // Reset, active low
   input wire logic ce, // Clock enable
   input wire mcss_cfg_t cfg, // Configuration options
   input wire mcss_osc_t osc, // Oscillator ticks
   input wire logic wake, // Wake pulse
   input wire logic [7:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Write strobe
   input wire mcss_tick_t tick, // Derived clock enables
   input wire logic fast_osc_en, // Fast oscillator enable
   input wire logic slow_xtal_en, // Slow crystal enable
   input wire logic slow_xtal_lp, // Slow crystal low power
   input wire logic [1:0] irc_freq_sel, // Fast RC frequency
   input wire logic ext_filter_en, // External clock filter on
   input wire logic xtal_pins_free, // Crystal pins as I/O
   input wire logic on_sub // Processor on substitute clock
);
   // Raw slow ticks picked by the configuration
   wire logic sub_src = cfg.sub_is_rc ? osc.slow_rc : osc.slow_xtal; // Sub
   wire logic tbc_src = cfg.tbc_is_rc ? osc.slow_rc : osc.slow_xtal; // Base
   wire logic slow_src = cfg.slow_is_rc ? osc.slow_rc : osc.slow_xtal; // Slow
   wire logic all_rc = cfg.slow_is_rc & cfg.sub_is_rc
      & cfg.tbc_is_rc; // Slow crystal unused

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // Registered outputs hold reset values at the first edge, so guard
   a_sub_follows: assert property ($past(rst_n) && $past(ce) |->
      tick.sub == $past(sub_src)) else $error("sub tick off source");
   a_tbc_timers: assert property ($past(rst_n) && $past(ce) |->
      tick.time_base_control_register == $past(tbc_src) && tick.tm == $past(tbc_src))
      else $error("time base or timer tick off source");
   a_lcd_sub: assert property ($past(rst_n) && $past(ce) |->
      tick.lcd == $past(sub_src)) else $error("lcd tick off sub source");
   a_lp_write: assert property (ce && reg_wr && reg_addr == MCSS_TBC_OFS
      |-> ##2 slow_xtal_lp == $past(reg_wdata[MCSS_TBC_CRYSTAL_LOW_POWER_SELECT], 2))
      else $error("low power output not written value");
   a_pins_free: assert property (xtal_pins_free |-> all_rc
      && !slow_xtal_en) else $error("crystal pins freed while in use");
   a_filter_off: assert property (cfg.ext_filter_off |->
      !ext_filter_en) else $error("filter on while disabled");
   a_irc_freq: assert property ($past(rst_n) && $past(ce) |->
      irc_freq_sel == $past(cfg.irc_freq)) else $error("rc frequency wrong");
   // Tick and wake state are judged in the cycle that made the tick
   a_slow_only: assert property ($past(rst_n) && $past(ce)
      && !fast_osc_en && !$past(on_sub) && tick.sys |-> $past(slow_src))
      else $error("sys tick not slow");
   a_wake_sub: assert property (ce && wake |=> on_sub)
      else $error("no substitute clock after wake");
   a_wdt_sub: assert property (!cfg.wdt_from_sys |->
      tick.wdt == tick.sub)
      else $error("watchdog tick differs from sub tick");

   // Main scenarios seen at least once
   c_wake: cover property (wake ##1 on_sub);
   c_fast_stop: cover property ($fell(fast_osc_en));
   c_lp_on: cover property ($rose(slow_xtal_lp));
endmodule // mcss_checker

bind mcss_top mcss_checker i_mcss_checker (.core_clk(core_clk),
   .rst_n(rst_n), .ce(ce), .cfg(cfg), .osc(osc), .wake(wake),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .tick(tick), .fast_osc_en(fast_osc_en), .slow_xtal_en(slow_xtal_en),
   .slow_xtal_lp(slow_xtal_lp), .irc_freq_sel(irc_freq_sel),
   .ext_filter_en(ext_filter_en), .xtal_pins_free(xtal_pins_free),
   .on_sub(on_sub));

// ### bench/testbench.sv
`timescale 1ns/10ps
// Self-checking bench for the clock source selection block
module testbench;
   import mcss_pkg::*;
   logic core_clk = 1'b0; // Block clock, 4 ns
   logic rst_n = 1'b0; // Reset, active low
   logic ce = 1'b1; // Clock enable, on except during one write
   mcss_cfg_t cfg = '0; // Configuration options
   mcss_cfg_t k; // Configuration under test
   mcss_osc_t osc = '0; // Oscillator ticks
   logic fast_stable = 1'b1; // Fast oscillator settled
   logic slow_stable = 1'b1; // Slow oscillator settled
   logic wake = 1'b0; // Wake pulse
   logic [7:0] reg_addr = 8'h00; // Register address
   logic [7:0] reg_wdata = 8'h00; // Register write data
   logic reg_wr = 1'b0; // Write strobe
   logic reg_rd = 1'b0; // Read strobe
   logic [7:0] reg_rdata; // Read data
   mcss_tick_t tick; // Derived clock enables
   logic fast_osc_en, slow_xtal_en, slow_xtal_lp; // Oscillator controls
   logic ext_filter_en, xtal_pins_free, on_sub; // Status levels
   logic [1:0] irc_freq_sel; // Fast RC frequency
   logic [7:0] cyc = 8'h00; // Phase counter for slow ticks
   logic [7:0] rv; // Last read value
   int miscompares = 0; // Mismatches seen
   int checks_done = 0; // Comparisons made
   int n_sys, n_sub, n_wdt; // Tick counts in a window

   always #2 core_clk = ~core_clk;

   // Fast ticks every cycle on the chosen source only, so a wrong pick
   // counts zero; slow crystal every 8 cycles, slow RC every 16
   always @(posedge core_clk) begin
      cyc <= cyc + 8'h01;
      osc.fast <= 4'h1 << cfg.fast_src;
      osc.slow_xtal <= (cyc[2:0] == 3'h0);
      osc.slow_rc <= (cyc[3:0] == 4'h0);
   end

   mcss_top i_mcss_top (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
      .cfg(cfg), .osc(osc), .fast_stable(fast_stable),
      .slow_stable(slow_stable), .wake(wake), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tick(tick), .fast_osc_en(fast_osc_en),
      .slow_xtal_en(slow_xtal_en), .slow_xtal_lp(slow_xtal_lp),
      .irc_freq_sel(irc_freq_sel), .ext_filter_en(ext_filter_en),
      .xtal_pins_free(xtal_pins_free), .on_sub(on_sub));

   // Compare and count
   task check(input string what, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One cycle write strobe
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // One cycle read strobe, data taken in the following cycle
   task rd(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      rv = reg_rdata;
   endtask

   // Let a source switch settle, then count ticks over 256 cycles;
   // 256 is a multiple of every period, so phase does not matter
   task count;
      repeat (300) @(negedge core_clk);
      n_sys = 0;
      n_sub = 0;
      n_wdt = 0;
      repeat (256) begin
         @(negedge core_clk);
         n_sys += int'(tick.sys === 1'b1);
         n_sub += int'(tick.sub === 1'b1);
         n_wdt += int'(tick.wdt === 1'b1);
      end
   endtask

   // Reset held 4 cycles with a new configuration
   task do_reset(input mcss_cfg_t c);
      @(posedge core_clk);
      rst_n <= 1'b0;
      cfg <= c;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
   endtask

   // Verdict and end of run
   task test_done;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Hang guard, well beyond the expected 10k cycles
   initial begin
      #200000;
      $display("watchdog expired");
      miscompares++;
      test_done();
   end

   initial begin
      do_reset('0);
      // Reset values, the low power bit and an unmapped place
      rd(MCSS_SMR_OFS);
      check("smr reset", 16'(rv & MCSS_SMR_WMASK), 16'(MCSS_SMR_RST));
      rd(MCSS_TBC_OFS);
      check("tbc reset", 16'(rv), 16'h0000);
      check("lp reset", 16'(slow_xtal_lp), 16'h0000);
      wr(MCSS_TBC_OFS, 8'hFF);
      rd(MCSS_TBC_OFS);
      check("tbc read", 16'(rv), 16'h0001);
      check("lp set", 16'(slow_xtal_lp), 16'h0001);
      rd(8'h05);
      check("unmapped", 16'(rv), 16'h0000);
      $display("test registers done");
      // Every divide code on the slow speed setting, low power kept on
      for (int c = 0; c < 8; c++) begin
         wr(MCSS_SMR_OFS, 8'(c << 5));
         count();
         check("sys rate", 16'(n_sys), (c < 2) ? 16'h0020 :
            16'(16'h0100 >> (8 - c)));
         check("fast osc", 16'(fast_osc_en), 16'(c >= 2));
         check("sub low power", 16'(n_sub), 16'h0020);
      end
      wr(MCSS_SMR_OFS, 8'h01);
      count();
      check("full rate", 16'(n_sys), 16'h0100);
      wr(MCSS_TBC_OFS, 8'h00);
      rd(MCSS_TBC_OFS);
      check("lp clear", 16'(slow_xtal_lp), 16'h0000);
      $display("test divide done");
      // One reset per fast source with mixed slow choices
      for (int s = 0; s < 4; s++) begin
         k = {2'(s), 2'(s % 3), 1'b0, s[0], s[1], s[0], s[0], 1'b1};
         do_reset(k);
         count();
         check("fast src", 16'(n_sys), 16'h0100);
         check("sub rate", 16'(n_sub),
            k.sub_is_rc ? 16'h0010 : 16'h0020);
         check("wdt rate", 16'(n_wdt), k.wdt_from_sys ? 16'h0040 :
            k.sub_is_rc ? 16'h0010 : 16'h0020);
         check("irc freq", 16'(irc_freq_sel), 16'(k.irc_freq));
         check("filter", 16'(ext_filter_en), 16'(s == 2));
         check("pins free", 16'(xtal_pins_free), 16'(s == 3));
         check("xtal en", 16'(slow_xtal_en), 16'(s != 3));
         wr(MCSS_SMR_OFS, 8'h00);
         count();
         check("slow src", 16'(n_sys),
            k.slow_is_rc ? 16'h0010 : 16'h0020);
      end
      // External clock with its noise filter turned off
      k.fast_src = MCSS_FAST_EXT;
      k.ext_filter_off = 1'b1;
      do_reset(k);
      count();
      check("ext rate", 16'(n_sys), 16'h0100);
      check("filter off", 16'(ext_filter_en), 16'h0000);
      wr(MCSS_SMR_OFS, 8'h00);
      repeat (100) @(negedge core_clk);
      check("fast off", 16'(fast_osc_en), 16'h0000);
      // Clock enable low: a write in that cycle is not taken
      @(posedge core_clk);
      ce <= 1'b0;
      wr(MCSS_TBC_OFS, 8'h01);
      ce <= 1'b1;
      rd(MCSS_TBC_OFS);
      check("ce freeze", 16'(rv), 16'h0000);
      $display("test sources done");
      // Wake while the fast path is still starting up: the processor
      // stays on the substitute clock until the switch reaches it
      wr(MCSS_SMR_OFS, 8'h01);
      @(posedge core_clk);
      wake <= 1'b1;
      @(posedge core_clk);
      wake <= 1'b0;
      @(negedge core_clk);
      check("on sub", 16'(on_sub), 16'h0001);
      repeat (300) @(negedge core_clk);
      check("sub left", 16'(on_sub), 16'h0000);
      $display("test wake done");
      test_done();
   end
endmodule // testbench
